//--- testbench/ingress_model.sv
// Ingress parser model: presents one parsed header per send request.
// Assumes send is driven by the bench just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module ingress_model (
	input wire logic clock, // Switch clock
	input wire logic send, // Present pkt next cycle
	input wire acl_pkg::pkt_hdr_t pkt, // Header to present
	output var logic hdr_valid, // Header strobe
	output var acl_pkg::pkt_hdr_t hdr // Header lines
);
	import acl_pkg::*;
	initial begin
		hdr_valid = 1'b0;
		hdr = '0;
	end
	// Idle lines toggle so a stale header never passes for a live one
	always @(posedge clock) begin
		hdr_valid <= send;
		hdr <= send ? pkt : ~hdr;
	end
endmodule // ingress_model
`default_nettype wire

//--- testbench/test_port_auth_acl_filter.sv
// Self-checking bench: register access, rule programming and packet verdicts.
// Assumes the ingress model feeds headers and the bench acts as host.
`timescale 1ns/10ps
`default_nettype none
module test_port_auth_acl_filter;
	import acl_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic send = 1'b0;
	logic hdr_valid, reg_rvalid, verdict_valid;
	logic [7:0] reg_rdata;
	logic [NUM_RULES-1:0] timer_event;
	pkt_hdr_t pkt = '0;
	pkt_hdr_t hdr;
	verdict_t verdict;
	rule_entry_t ent;
	int err_total = 0;
	int checks = 0;
	logic [7:0] tev2_q = 8'h00;
	logic [7:0] tev3_q = 8'h00;
	always #2.5 clock = ~clock;
	// Timer pulses last one cycle, so they are counted here rather than polled
	always @(posedge clock) begin
		if (timer_event[2] === 1'b1) begin
			tev2_q <= tev2_q + 8'h01;
		end
		if (timer_event[3] === 1'b1) begin
			tev3_q <= tev3_q + 8'h01;
		end
	end
	ingress_model model (.clock(clock), .send(send), .pkt(pkt), .hdr_valid(hdr_valid), .hdr(hdr));
	port_auth_acl_filter uut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.hdr_valid(hdr_valid), .hdr(hdr), .verdict_valid(verdict_valid), .verdict(verdict),
		.timer_event(timer_event));
	task automatic results();
		if (err_total == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_verdict(input verdict_t got, input verdict_t exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			#1;
			if (reg_rvalid === 1'b1) begin
				cmp_byte(reg_rdata, exp);
				return;
			end
			@(posedge clock);
		end
		err_total++;
		results();
	endtask
	// Staging bytes go low byte first, then the command byte commits them
	task automatic stage(input logic [ENTRY_W-1:0] v, input int nb, input logic [7:0] cmd);
		for (int k = 0; k < nb; k++) begin
			wr(ADDR_IND_CTRL1, 8'(k));
			wr(ADDR_IND_DATA, v[8*k +: 8]);
		end
		wr(ADDR_IND_CTRL0, cmd);
	endtask
	task automatic pkt_chk(input logic [15:0] ty, input verdict_t exp);
		@(posedge clock);
		pkt.ether_type <= ty;
		send <= 1'b1;
		@(posedge clock);
		send <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			#1;
			if (verdict_valid === 1'b1) begin
				cmp_verdict(verdict, exp);
				return;
			end
		end
		err_total++;
		results();
	endtask
	initial begin
		pkt.qos_prio = 3'h2;
		pkt.vlan_tagged = 1'b1;
		pkt.lookup_map = 5'h0a;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		rd(ADDR_AUTH_BASE, 8'h00);
		rd(8'h99, 8'h00);
		wr(ADDR_AUTH_BASE, 8'hff);
		rd(ADDR_AUTH_BASE, 8'h07);
		wr(ADDR_AUTH_BASE, 8'h00);
		pkt_chk(16'h1234, {5'h0a, 1'b0, 1'b0, 3'h2, 1'b0, 3'h0});
		wr(ADDR_AUTH_BASE, 8'h01);
		pkt_chk(16'h1234, {5'h00, 1'b1, 1'b0, 3'h2, 1'b0, 3'h0});
		wr(ADDR_AUTH_BASE, 8'h03);
		pkt_chk(16'h1234, {5'h10, 1'b0, 1'b1, 3'h2, 1'b0, 3'h0});
		ent = '0;
		ent.rule_mode = RULE_MAC;
		ent.rule_enable_sel = ENB_TYPE;
		ent.eq_match = 1'b1;
		ent.payload[15:0] = 16'h88b5;
		ent.act = {PM_FORCE, 3'h5, 1'b1, 3'h6, 2'b11, 5'h03};
		stage(ENTRY_W'(ent), ENTRY_BYTES, 8'h80);
		ent.act.prio = 3'h1;
		ent.act.fwd_map = 5'h0c;
		stage(ENTRY_W'(ent), ENTRY_BYTES, 8'h81);
		// Read back entry 0, not the last one staged, so the staging word really reloads
		ent.act.prio = 3'h5;
		ent.act.fwd_map = 5'h03;
		wr(ADDR_IND_CTRL0, 8'h40);
		repeat (2) @(posedge clock);
		for (int k = 0; k < ENTRY_BYTES; k++) begin
			wr(ADDR_IND_CTRL1, 8'(k));
			rd(ADDR_IND_DATA, ent[8*k +: 8]);
		end
		stage(ENTRY_W'({16'h0002, 4'h1}), 3, 8'ha0);
		stage(ENTRY_W'({16'h0001, 4'h0}), 3, 8'ha1);
		wr(ADDR_AUTH_BASE, 8'h05);
		pkt_chk(16'h88b5, {5'h03, 1'b0, 1'b0, 3'h5, 1'b1, 3'h6});
		pkt_chk(16'h88b6, {5'h00, 1'b1, 1'b0, 3'h2, 1'b0, 3'h0});
		wr(ADDR_AUTH_BASE, 8'h07);
		pkt_chk(16'h1234, {5'h10, 1'b0, 1'b1, 3'h2, 1'b0, 3'h0});
		wr(ADDR_AUTH_BASE, 8'h04);
		pkt_chk(16'h88b5, {5'h03, 1'b0, 1'b0, 3'h5, 1'b1, 3'h6});
		pkt_chk(16'h1234, {5'h0a, 1'b0, 1'b0, 3'h2, 1'b0, 3'h0});
		ent = '0;
		ent.rule_mode = RULE_MAC;
		ent.rule_enable_sel = ENB_COUNT;
		ent.eq_match = 1'b1;
		ent.payload[15:0] = 16'h0800;
		ent.act = 16'h0048;
		stage(ENTRY_W'(ent), ENTRY_BYTES, 8'h82);
		ent.payload[15:0] = 16'h0806;
		ent.act = 16'h0040;
		stage(ENTRY_W'(ent), ENTRY_BYTES, 8'h83);
		// Count value 2 in packet-count mode: the second hit raises the event
		pkt_chk(16'h0800, {5'h0a, 1'b0, 1'b0, 3'h2, 1'b0, 3'h0});
		cmp_byte(tev2_q, 8'h00);
		pkt_chk(16'h0800, {5'h0a, 1'b0, 1'b0, 3'h2, 1'b0, 3'h0});
		cmp_byte(tev2_q, 8'h01);
		// Count value 2 us in interval mode: hits closer than one tick keep it quiet
		for (int i = 0; i < 4; i++) begin
			pkt_chk(16'h0806, {5'h0a, 1'b0, 1'b0, 3'h2, 1'b0, 3'h0});
			repeat (150) @(posedge clock);
		end
		cmp_byte(tev3_q, 8'h00);
		repeat (450) @(posedge clock);
		cmp_byte(tev3_q, 8'h01);
		results();
	end
endmodule // test_port_auth_acl_filter
`default_nettype wire

//--- verilog/acl_pkg.sv
// Constants, field layouts and carrier types for the port admission and rule filter.
// Assumes one 200 MHz switch clock shared by every user of this package.
package acl_pkg;

	localparam int NUM_RULES = 16;
	localparam int RIDX_W = 4;
	localparam int PORT_MAP_W = 5;
	localparam int AUTH_PORTS = 4;
	localparam int CPU_PORT = 4;
	localparam int ENTRY_BYTES = 13;
	localparam int ENTRY_W = ENTRY_BYTES * 8;
	localparam int COUNT_W = 11;

	localparam logic [7:0] ADDR_IND_CTRL0 = 8'h6e;
	localparam logic [7:0] ADDR_IND_CTRL1 = 8'h6f;
	localparam logic [7:0] ADDR_IND_DATA = 8'ha0;
	localparam logic [7:0] ADDR_AUTH_BASE = 8'h15;
	localparam logic [7:0] ADDR_PORT_STRIDE = 8'h10;

	localparam int CTL_WR_BIT = 7;
	localparam int CTL_RD_BIT = 6;
	localparam int CTL_SET_BIT = 5;
	localparam logic [7:0] CTL_KEEP_MASK = 8'h3f;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	localparam logic [1:0] AUTH_PASS = 2'b00;
	localparam logic [1:0] AUTH_BLOCK = 2'b01;
	localparam logic [1:0] AUTH_TRAP = 2'b11;

	localparam logic [1:0] RULE_OFF = 2'b00;
	localparam logic [1:0] RULE_MAC = 2'b01;
	localparam logic [1:0] RULE_IP = 2'b10;
	localparam logic [1:0] RULE_L4 = 2'b11;

	localparam logic [1:0] ENB_COUNT = 2'b00;
	localparam logic [1:0] ENB_TYPE = 2'b01;
	localparam logic [1:0] ENB_ADDR = 2'b10;
	localparam logic [1:0] ENB_IP_MASK = 2'b01;
	localparam logic [1:0] ENB_IP_SD = 2'b10;
	localparam logic [1:0] ENB_PROTO = 2'b00;
	localparam logic [1:0] ENB_TCP = 2'b01;
	localparam logic [1:0] ENB_UDP = 2'b10;
	localparam logic [1:0] ENB_SEQ = 2'b11;

	localparam logic [1:0] PC_OFF = 2'b00;
	localparam logic [1:0] PC_EITHER = 2'b01;
	localparam logic [1:0] PC_IN = 2'b10;

	localparam logic [1:0] PM_KEEP = 2'b00;
	localparam logic [1:0] PM_HIGHER = 2'b01;
	localparam logic [1:0] PM_LOWER = 2'b10;
	localparam logic [1:0] PM_FORCE = 2'b11;

	localparam logic [1:0] MM_KEEP = 2'b00;
	localparam logic [1:0] MM_OR = 2'b01;
	localparam logic [1:0] MM_AND = 2'b10;

	localparam int UNIT_BIT = 4;
	localparam int ALGO_BIT = 3;

	localparam int CLK_NS = 5;
	localparam int US_NS = 1000;
	localparam int US_CYCLES = (US_NS + CLK_NS - 1) / CLK_NS;
	localparam int MS_US = 1000;

	typedef struct packed {
		logic [4:0] rsvd;
		logic acl_en;
		logic [1:0] auth_mode_sel;
	} auth_ctrl_t;

	typedef struct packed {
		logic [1:0] prio_mode;
		logic [2:0] prio;
		logic remark_en;
		logic [2:0] remark_priority;
		logic [1:0] map_mode;
		logic [PORT_MAP_W-1:0] fwd_map;
	} rule_action_t;

	typedef struct packed {
		logic [1:0] rule_mode;
		logic [1:0] rule_enable_sel;
		logic src_sel;
		logic eq_match;
		logic [63:0] payload;
		logic [1:0] port_cmp_mode;
		logic [7:0] ip_next_header_val;
		logic flag_match_en;
		logic [5:0] tcp_flag;
		rule_action_t act;
		logic pad;
	} rule_entry_t;

	typedef struct packed {
		logic [15:0] rule_group_bitmap;
		logic [RIDX_W-1:0] first_rule_index;
	} rule_set_t;

	typedef struct packed {
		logic [47:0] dst_mac;
		logic [47:0] src_mac;
		logic [15:0] ether_type;
		logic [31:0] dst_ip;
		logic [31:0] src_ip;
		logic [7:0] ip_proto;
		logic is_tcp;
		logic is_udp;
		logic [15:0] src_port;
		logic [15:0] dst_port;
		logic [31:0] tcp_seq;
		logic [5:0] tcp_flags;
		logic vlan_tagged;
		logic [2:0] qos_prio;
		logic [PORT_MAP_W-1:0] lookup_map;
		logic [2:0] port;
	} pkt_hdr_t;

	typedef struct packed {
		logic [PORT_MAP_W-1:0] fwd_map;
		logic drop;
		logic to_cpu;
		logic [2:0] prio;
		logic remark;
		logic [2:0] remark_prio;
	} verdict_t;

endpackage

//--- verilog/port_auth_acl_filter.sv
// Per-port ingress admission: authorization mode, rule table matching, rule-set arbitration, actions.
// Assumes the host drives byte-wide register strobes and the parser presents one header per valid cycle.
//
// Function
// - Mode 00 passes all port traffic, always authorized.
// - Pass mode with filtering: misses pass, hits take the rule action.
// - Mode 01 blocks every incoming packet, source address unchecked.
// - Block mode with filtering: only rule hits get through.
// - Mode 11 sends every packet to the CPU port.
// - Trap mode with filtering: misses go to CPU instead of dropping.
// - Authorization register: filter enable bit 2, mode bits 1 to 0.
// - Entry mode: 00 off, 01 MAC, 10 IP, 11 TCP/UDP.
// - MAC entry selector 00 is a timer; 11-bit count, map MSB picks unit.
// - Map bit 3 low: down-counter per unit, event on expiry without packet.
// - Map bit 3 high: count matches, event at count value, then restart.
// - MAC selector: 01 ether type, 10 address, 11 both.
// - IP selector: 01 masked address and, if nonzero, protocol; 10 source equals destination.
// - Transport selector: 00 protocol, 01 TCP port, 10 UDP port, 11 sequence.
// - Select bit picks source or destination; equality bit picks equal or unequal.
// - Port compare: off, either bound, inside range, outside range.
// - Flag enable adds a six-bit TCP flag compare.
// - Priority mode: keep, greater, smaller, or force the rule priority.
// - Remark enable rewrites VLAN priority of tagged matches.
// - Map mode keeps, ORs, ANDs or replaces the lookup map.
// - Rule set matches when all selected entries match; action from first index.
// - Lowest first-rule index wins among matching rule sets.
`timescale 1ns/10ps
`default_nettype none
module port_auth_acl_filter #(
	parameter int SETS_PER_PORT = 4
) (
	input wire logic clock, // Switch clock, 200 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	input wire logic [7:0] reg_wdata, // Register write data
	output logic [7:0] reg_rdata, // Register read data
	output logic reg_rvalid, // Read data valid pulse
	input wire logic hdr_valid, // Header present
	input wire acl_pkg::pkt_hdr_t hdr, // Parsed header and lookup result
	output logic verdict_valid, // Verdict present pulse
	output var acl_pkg::verdict_t verdict, // Admission verdict
	output logic [acl_pkg::NUM_RULES-1:0] timer_event // Per-entry timer pulses
);
	import acl_pkg::*;

	localparam int NUM_SETS = PORT_MAP_W * SETS_PER_PORT;
	localparam logic [PORT_MAP_W-1:0] CPU_MAP = PORT_MAP_W'(1 << CPU_PORT);

	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	auth_ctrl_t auth_q [AUTH_PORTS];
	logic [ENTRY_W-1:0] stage_q;
	rule_set_t rset_q [NUM_SETS];
	logic load_q;
	logic mem_wr;
	logic mem_rd;
	logic [ENTRY_W-1:0] mem_rdata;
	logic [NUM_RULES-1:0][ENTRY_W-1:0] mem_words;
	rule_entry_t entries [NUM_RULES];
	logic [NUM_RULES-1:0] match_now;
	logic [NUM_RULES-1:0] match_q;
	pkt_hdr_t hdr_q;
	logic valid_q;
	logic [$clog2(US_CYCLES)-1:0] us_cnt_q;
	logic [$clog2(MS_US)-1:0] ms_cnt_q;
	logic tick_us_q;
	logic tick_ms_q;
	logic hit;
	logic [RIDX_W-1:0] best;
	rule_action_t act;
	auth_ctrl_t port_auth;
	logic apply;
	logic [PORT_MAP_W-1:0] act_map;
	logic [2:0] act_prio;
	verdict_t verdict_d;

	function automatic logic [7:0] auth_addr(input int p);
		auth_addr = 8'(ADDR_AUTH_BASE + p * ADDR_PORT_STRIDE);
	endfunction

	// Register writes; commands in ctrl0 act once and are not stored
	assign mem_wr = reg_wr && (reg_addr == ADDR_IND_CTRL0) && reg_wdata[CTL_WR_BIT] && !reg_wdata[CTL_SET_BIT];
	assign mem_rd = reg_wr && (reg_addr == ADDR_IND_CTRL0) && reg_wdata[CTL_RD_BIT] && !reg_wdata[CTL_SET_BIT];

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl0_q <= RESET_BYTE;
			ctrl1_q <= RESET_BYTE;
		end else if (reg_wr && (reg_addr == ADDR_IND_CTRL0)) begin
			ctrl0_q <= reg_wdata & CTL_KEEP_MASK;
		end else if (reg_wr && (reg_addr == ADDR_IND_CTRL1)) begin
			ctrl1_q <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < AUTH_PORTS; p++) begin
				auth_q[p] <= '0;
			end
		end else if (reg_wr) begin
			for (int p = 0; p < AUTH_PORTS; p++) begin
				if (reg_addr == auth_addr(p)) begin
					auth_q[p] <= '{rsvd: '0, acl_en: reg_wdata[2], auth_mode_sel: reg_wdata[1:0]};
				end
			end
		end
	end

	// Staging word: byte writes from the data register, or a readback of an entry or a rule set
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stage_q <= '0;
			load_q <= 1'b0;
		end else begin
			load_q <= mem_rd;
			if (load_q) begin
				stage_q <= mem_rdata;
			end else if (reg_wr && (reg_addr == ADDR_IND_CTRL0) && reg_wdata[CTL_RD_BIT] && reg_wdata[CTL_SET_BIT]) begin
				if (int'(reg_wdata[4:0]) < NUM_SETS) begin
					stage_q <= ENTRY_W'(rset_q[reg_wdata[4:0]]);
				end
			end else if (reg_wr && (reg_addr == ADDR_IND_DATA) && (int'(ctrl1_q[3:0]) < ENTRY_BYTES)) begin
				stage_q[ctrl1_q[3:0] * 8 +: 8] <= reg_wdata;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int s = 0; s < NUM_SETS; s++) begin
				rset_q[s] <= '0;
			end
		end else if (reg_wr && (reg_addr == ADDR_IND_CTRL0) && reg_wdata[CTL_WR_BIT] && reg_wdata[CTL_SET_BIT]) begin
			if (int'(reg_wdata[4:0]) < NUM_SETS) begin
				rset_q[reg_wdata[4:0]] <= stage_q[$bits(rule_set_t)-1:0];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= RESET_BYTE;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= RESET_BYTE;
				if (reg_addr == ADDR_IND_CTRL0) begin
					reg_rdata <= ctrl0_q;
				end else if (reg_addr == ADDR_IND_CTRL1) begin
					reg_rdata <= ctrl1_q;
				end else if ((reg_addr == ADDR_IND_DATA) && (int'(ctrl1_q[3:0]) < ENTRY_BYTES)) begin
					reg_rdata <= stage_q[ctrl1_q[3:0] * 8 +: 8];
				end else begin
					for (int p = 0; p < AUTH_PORTS; p++) begin
						if (reg_addr == auth_addr(p)) begin
							reg_rdata <= auth_q[p];
						end
					end
				end
			end
		end
	end

	rule_mem #(
		.WIDTH(ENTRY_W),
		.DEPTH(NUM_RULES),
		.AW(RIDX_W)
	) u_table (
		.clock(clock),
		.rst_b(rst_b),
		.wr_en(mem_wr),
		.wr_addr(reg_wdata[RIDX_W-1:0]),
		.wr_data(stage_q),
		.rd_en(mem_rd),
		.rd_addr(reg_wdata[RIDX_W-1:0]),
		.rd_data(mem_rdata),
		.words(mem_words)
	);

	// Time base for the count entries; the millisecond tick is derived from the microsecond one
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			us_cnt_q <= '0;
			ms_cnt_q <= '0;
			tick_us_q <= 1'b0;
			tick_ms_q <= 1'b0;
		end else begin
			tick_us_q <= (int'(us_cnt_q) == US_CYCLES - 1);
			tick_ms_q <= 1'b0;
			if (int'(us_cnt_q) == US_CYCLES - 1) begin
				us_cnt_q <= '0;
				if (int'(ms_cnt_q) == MS_US - 1) begin
					ms_cnt_q <= '0;
					tick_ms_q <= 1'b1;
				end else begin
					ms_cnt_q <= ms_cnt_q + 1'b1;
				end
			end else begin
				us_cnt_q <= us_cnt_q + 1'b1;
			end
		end
	end

	for (genvar r = 0; r < NUM_RULES; r++) begin : g_rule
		assign entries[r] = mem_words[r];
		rule_eval u_eval (
			.clock(clock),
			.rst_b(rst_b),
			.entry(entries[r]),
			.hdr(hdr),
			.hdr_valid(hdr_valid),
			.tick_us(tick_us_q),
			.tick_ms(tick_ms_q),
			.match(match_now[r]),
			.timer_event(timer_event[r])
		);
	end

	// First stage holds the header and the per-entry match vector
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hdr_q <= '0;
			match_q <= '0;
			valid_q <= 1'b0;
		end else begin
			valid_q <= hdr_valid;
			if (hdr_valid) begin
				hdr_q <= hdr;
				match_q <= match_now;
			end
		end
	end

	// Rule-set arbitration for the ingress port
	always_comb begin
		hit = 1'b0;
		best = '0;
		for (int k = 0; k < SETS_PER_PORT; k++) begin
			if (int'(hdr_q.port) * SETS_PER_PORT + k < NUM_SETS) begin
				if ((rset_q[int'(hdr_q.port) * SETS_PER_PORT + k].rule_group_bitmap != '0)
					&& ((rset_q[int'(hdr_q.port) * SETS_PER_PORT + k].rule_group_bitmap & ~match_q) == '0)
					&& (!hit || (rset_q[int'(hdr_q.port) * SETS_PER_PORT + k].first_rule_index < best))) begin
					hit = 1'b1;
					best = rset_q[int'(hdr_q.port) * SETS_PER_PORT + k].first_rule_index;
				end
			end
		end
	end

	assign act = entries[best].act;

	always_comb begin
		port_auth = '0;
		if (int'(hdr_q.port) < AUTH_PORTS) begin
			port_auth = auth_q[hdr_q.port[1:0]];
		end
		apply = port_auth.acl_en && hit;
		case (act.map_mode)
			MM_KEEP: act_map = hdr_q.lookup_map;
			MM_OR: act_map = hdr_q.lookup_map | act.fwd_map;
			MM_AND: act_map = hdr_q.lookup_map & act.fwd_map;
			default: act_map = act.fwd_map;
		endcase
		case (act.prio_mode)
			PM_KEEP: act_prio = hdr_q.qos_prio;
			PM_HIGHER: act_prio = (act.prio > hdr_q.qos_prio) ? act.prio : hdr_q.qos_prio;
			PM_LOWER: act_prio = (act.prio < hdr_q.qos_prio) ? act.prio : hdr_q.qos_prio;
			default: act_prio = act.prio;
		endcase
		verdict_d = '0;
		verdict_d.prio = hdr_q.qos_prio;
		if (apply) begin
			verdict_d.fwd_map = act_map;
			verdict_d.prio = act_prio;
			verdict_d.remark = act.remark_en && hdr_q.vlan_tagged;
			verdict_d.remark_prio = verdict_d.remark ? act.remark_priority : '0;
		end else begin
			case (port_auth.auth_mode_sel)
				AUTH_BLOCK: verdict_d.drop = 1'b1;
				AUTH_TRAP: begin
					verdict_d.fwd_map = CPU_MAP;
					verdict_d.to_cpu = 1'b1;
				end
				default: verdict_d.fwd_map = hdr_q.lookup_map;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			verdict <= '0;
			verdict_valid <= 1'b0;
		end else begin
			verdict_valid <= valid_q;
			if (valid_q) begin
				verdict <= verdict_d;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_auth0_write;
		reg_wr && (reg_addr == ADDR_AUTH_BASE);
	endsequence
	sequence s_auth0_read;
		reg_rd && !reg_wr && (reg_addr == ADDR_AUTH_BASE);
	endsequence

	a_verdict_latency: assert property (hdr_valid |-> ##2 verdict_valid)
		else $error("verdict not two cycles after header");
	a_pass_lookup: assert property (valid_q && !apply && (port_auth.auth_mode_sel == AUTH_PASS)
		|=> verdict.fwd_map == $past(hdr_q.lookup_map) && !verdict.drop)
		else $error("pass mode did not forward lookup map");
	a_block_drop: assert property (valid_q && !apply && (port_auth.auth_mode_sel == AUTH_BLOCK)
		|=> verdict.drop && (verdict.fwd_map == '0))
		else $error("block mode let a miss through");
	a_trap_cpu: assert property (valid_q && !apply && (port_auth.auth_mode_sel == AUTH_TRAP)
		|=> verdict.to_cpu && (verdict.fwd_map == CPU_MAP))
		else $error("trap mode miss not sent to cpu");
	a_auth_readback: assert property (s_auth0_write ##1 !reg_wr ##1 s_auth0_read |=> reg_rvalid
		&& (reg_rdata == {5'h00, $past(reg_wdata[2:0], 3)}))
		else $error("authorization register readback wrong");
	a_force_prio: assert property (valid_q && apply && (act.prio_mode == PM_FORCE)
		|=> verdict.prio == $past(act.prio))
		else $error("forced priority not applied");
	a_remark_tagged: assert property (valid_q && apply && act.remark_en && hdr_q.vlan_tagged
		|=> verdict.remark && (verdict.remark_prio == $past(act.remark_priority)))
		else $error("remark not applied to tagged hit");
	a_map_replace: assert property (valid_q && apply && (act.map_mode == 2'b11)
		|=> verdict.fwd_map == $past(act.fwd_map))
		else $error("replace map mode not applied");
endmodule // port_auth_acl_filter
`default_nettype wire

//--- verilog/rule_eval.sv
// One rule entry: header comparison and the interval / packet-count timer of count entries.
// Assumes header inputs are valid and stable while hdr_valid is high.
`timescale 1ns/10ps
`default_nettype none
module rule_eval (
	input wire logic clock, // Switch clock
	input wire logic rst_b, // Async reset, active low
	input wire acl_pkg::rule_entry_t entry, // Rule entry contents
	input wire acl_pkg::pkt_hdr_t hdr, // Packet header fields
	input wire logic hdr_valid, // Header present this cycle
	input wire logic tick_us, // One pulse per microsecond
	input wire logic tick_ms, // One pulse per millisecond
	output logic match, // Entry matches header
	output logic timer_event // Timer expiry or terminal count pulse
);
	import acl_pkg::*;

	logic [47:0] mac_sel;
	logic [31:0] ip_sel;
	logic [15:0] port_sel;
	logic [15:0] port_max;
	logic [15:0] port_min;
	logic port_in;
	logic port_ok;
	logic flag_ok;
	logic cmp;
	logic live;
	logic count_mode;
	logic tick;
	logic armed_q;
	logic [COUNT_W-1:0] limit;
	logic [COUNT_W-1:0] cnt_q;

	always_comb begin
		mac_sel = entry.src_sel ? hdr.src_mac : hdr.dst_mac;
		ip_sel = entry.src_sel ? hdr.src_ip : hdr.dst_ip;
		port_sel = entry.src_sel ? hdr.src_port : hdr.dst_port;
		port_max = entry.payload[63:48];
		port_min = entry.payload[47:32];
		port_in = (port_sel >= port_min) && (port_sel <= port_max);
		flag_ok = !entry.flag_match_en || (hdr.tcp_flags == entry.tcp_flag);
		case (entry.port_cmp_mode)
			PC_OFF: port_ok = 1'b1;
			PC_EITHER: port_ok = (port_sel == port_max) || (port_sel == port_min);
			PC_IN: port_ok = port_in;
			default: port_ok = !port_in;
		endcase
		cmp = 1'b0;
		live = 1'b1;
		case (entry.rule_mode)
			RULE_MAC: begin
				case (entry.rule_enable_sel)
					ENB_TYPE: cmp = hdr.ether_type == entry.payload[15:0];
					ENB_ADDR: cmp = mac_sel == entry.payload[63:16];
					default: cmp = (mac_sel == entry.payload[63:16]) && (hdr.ether_type == entry.payload[15:0]);
				endcase
			end
			RULE_IP: begin
				case (entry.rule_enable_sel)
					ENB_IP_MASK: cmp = (((ip_sel ^ entry.payload[63:32]) & entry.payload[31:0]) == '0)
						&& ((entry.ip_next_header_val == '0) || (hdr.ip_proto == entry.ip_next_header_val));
					ENB_IP_SD: cmp = hdr.src_ip == hdr.dst_ip;
					default: live = 1'b0;
				endcase
			end
			RULE_L4: begin
				case (entry.rule_enable_sel)
					ENB_PROTO: cmp = hdr.ip_proto == entry.ip_next_header_val;
					ENB_TCP: cmp = port_ok;
					ENB_UDP: cmp = port_ok;
					default: cmp = hdr.tcp_seq == entry.payload[63:32];
				endcase
				if (entry.rule_enable_sel == ENB_UDP) begin
					live = hdr.is_udp;
				end else if (entry.rule_enable_sel != ENB_PROTO) begin
					live = hdr.is_tcp && flag_ok;
				end
			end
			default: live = 1'b0;
		endcase
		match = live && (entry.eq_match ? cmp : !cmp);
	end

	// Count value is spread over the action bits; the forward map picks unit and algorithm
	assign count_mode = (entry.rule_mode == RULE_MAC) && (entry.rule_enable_sel == ENB_COUNT);
	assign limit = entry.act[15:5];
	assign tick = entry.act.fwd_map[UNIT_BIT] ? tick_ms : tick_us;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			armed_q <= 1'b0;
			timer_event <= 1'b0;
		end else begin
			timer_event <= 1'b0;
			if (!count_mode || (limit == '0)) begin
				cnt_q <= '0;
				armed_q <= 1'b0;
			end else if (entry.act.fwd_map[ALGO_BIT]) begin
				armed_q <= 1'b0;
				if (hdr_valid && match) begin
					if ((cnt_q + 11'h001) == limit) begin
						cnt_q <= '0;
						timer_event <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 11'h001;
					end
				end
			end else if (hdr_valid && match) begin
				cnt_q <= limit;
				armed_q <= 1'b1;
			end else if (armed_q && tick) begin
				if (cnt_q == 11'h001) begin
					cnt_q <= '0;
					armed_q <= 1'b0;
					timer_event <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 11'h001;
				end
			end
		end
	end
endmodule // rule_eval
`default_nettype wire

//--- verilog/rule_mem.sv
// Rule entry storage: every word is visible in parallel for matching, plus one registered read port.
// Assumes the owner never writes and reads the same word in one cycle.
`timescale 1ns/10ps
`default_nettype none
module rule_mem #(
	parameter int WIDTH = 104,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clock, // Switch clock
	input wire logic rst_b, // Async reset, active low
	input wire logic wr_en, // Write strobe
	input wire logic [AW-1:0] wr_addr, // Write index
	input wire logic [WIDTH-1:0] wr_data, // Write word
	input wire logic rd_en, // Read strobe
	input wire logic [AW-1:0] rd_addr, // Read index
	output logic [WIDTH-1:0] rd_data, // Registered read word
	output logic [DEPTH-1:0][WIDTH-1:0] words // All words
);
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			words <= '0;
		end else if (wr_en) begin
			words[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= words[rd_addr];
		end
	end
endmodule // rule_mem
`default_nettype wire
